/* bm_map.svh */
`ifndef BM_MAP_SVH
`define BM_MAP_SVH
// ==========================================================================
// Register offsets of the low control and instrumentation page.
`define BM_A_STATUS  8'h01
`define BM_A_ETM_H   8'h02
`define BM_A_ETM_L   8'h03
`define BM_A_CTR     8'h06
`define BM_A_NVC     8'h07
`define BM_A_VOLT_H  8'h0c
`define BM_A_VOLT_L  8'h0d
`define BM_A_CUR_H   8'h0e
`define BM_A_CUR_L   8'h0f
`define BM_A_ACC_H   8'h10
`define BM_A_ACC_L   8'h11
`define BM_A_TMP_H   8'h18
`define BM_A_TMP_L   8'h19
// ==========================================================================
// Nonvolatile blocks and scratch memory.
`define BM_NV_BASE   8'h20
`define BM_NV_LAST   8'h47
`define BM_NV_BYTES  40
`define BM_NV_B1     6'h10
`define BM_NV_B2     6'h20
`define BM_NV_STAT   6'h11
`define BM_NV_BIAS_H 6'h12
`define BM_NV_BIAS_L 6'h13
`define BM_NV_CTR    6'h14
`define BM_RAM_BASE  8'h80
`define BM_RAM_LAST  8'h8f
`define BM_RAM_BYTES 16
// ==========================================================================
// Field positions.
`define BM_ST_SLEEP  5
`define BM_ST_OPSEL  4
`define BM_ST_CINI   1
`define BM_ST_CTYPE  0
`define BM_NVC_BUSY  7
`define BM_NVC_LOCK  6
// ==========================================================================
// Timing and scaling.
`define BM_CLK_NS    64'd4
`define BM_T_CUR_NS  64'd3520000000
`define BM_T_MEAS_NS 64'd55000000
`define BM_T_ETM_NS  64'd56000000000
`define BM_T_OFS_NS  64'd3600000000000
`define BM_ACC_DIV   20'sd4091
`define BM_VOLT_MAX  16'h03ff
`define BM_COPY_CYC  16'h0008
`endif

/* bm_pkg.sv */
// ==========================================================================
// Shared types of the battery monitor register map.
package bm_pkg;
	// Host command codes on the command port.
	typedef enum logic [2:0] {
		BM_OP_READ    = 3'h0,
		BM_OP_WRITE   = 3'h1,
		BM_OP_COPY    = 3'h2,
		BM_OP_RECALL  = 3'h3,
		BM_OP_LOCK    = 3'h4,
		BM_OP_REFRESH = 3'h5,
		BM_OP_END     = 3'h6
	} bm_op_t;
	typedef logic [7:0] bm_byte_t;
endpackage : bm_pkg

/* bm_register_map.sv */
`include "bm_map.svh"
module bm_register_map
	import bm_pkg::*;
#(
	parameter longint unsigned CUR_CYC  = `BM_T_CUR_NS / `BM_CLK_NS,
	parameter longint unsigned MEAS_CYC = `BM_T_MEAS_NS / `BM_CLK_NS,
	parameter longint unsigned ETM_CYC  = `BM_T_ETM_NS / `BM_CLK_NS,
	parameter longint unsigned OFS_CYC  = `BM_T_OFS_NS / `BM_CLK_NS,
	parameter logic [15:0]     COPY_CYC = `BM_COPY_CYC
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic        hc_valid,
	input  wire bm_op_t      hc_op,
	input  wire logic [7:0]  hc_addr,
	input  wire logic [7:0]  hc_wdata,
	input  wire logic [15:0] cur_raw,
	input  wire logic [15:0] cur_zero,
	input  wire logic [15:0] volt_raw,
	input  wire logic [15:0] temp_raw,
	input  wire logic [1:0]  charge_state_in,
	input  wire logic        charge_done,
	input  wire logic        fast_charge_start,
	input  wire logic        fast_charging,
	output logic [7:0]       hc_rdata,
	output logic             hc_rvalid,
	output logic             charge_state_hi,
	output logic             charge_state_lo,
	output logic             sleep_enable,
	output logic             net_opcode_sel,
	output logic             charge_init_sel,
	output logic             charge_type,
	output logic [7:0]       charge_time_limit,
	output logic             copy_busy
);
	// ======================================================================
	// Storage and state.
	logic [39:0]        div_cnt [4];   // Rate dividers.
	logic [3:0]         tick;          // Cur, meas, timer, offset pulses.
	logic signed [15:0] cur_ofs;       // Internal zero offset estimate.
	logic signed [15:0] cur_reg;       // Reported current.
	logic signed [15:0] acc_reg;       // Charge accumulator.
	logic signed [19:0] acc_res;       // Sub-count charge remainder.
	logic [15:0]        volt_reg;      // Battery voltage result.
	logic [15:0]        temp_reg;      // Temperature result.
	logic [15:0]        etm_reg;       // Elapsed time.
	logic               done_lat;      // Latched charge completion.
	logic               cfg_pend;      // Status load owed after reset.
	logic [2:0]         blk_lock;      // Permanent block locks.
	logic               lock_en;       // Arms the lock command.
	logic [15:0]        busy_cnt;      // Copy in progress timer.
	logic [7:0]         nv  [`BM_NV_BYTES];
	logic [7:0]         sh  [`BM_NV_BYTES];
	logic [7:0]         ram [`BM_RAM_BYTES];
	logic               frz_on;        // A pair is frozen.
	logic [7:0]         frz_addr;      // Upper address of frozen pair.
	logic [7:0]         frz_lo;        // Frozen lower byte.
	logic [7:0]         rd_byte;       // Live read value.
	logic signed [17:0] cur_diff;      // Corrected current, wide.
	logic signed [15:0] cur_corr;      // Corrected current, clamped.
	logic               cmd, wr, rd;   // Decoded command strobes.
	logic [5:0]         nv_idx;        // Shadow index of host address.
	logic               nv_hit;        // Host address in a block.
	logic [1:0]         nv_blk;        // Block of host address.
	logic [15:0]        pair_up;       // Pair whose upper byte is addressed.
	logic [15:0]        pair_dn;       // Pair whose lower byte is addressed.

	localparam longint unsigned DIV_LEN [4] =
		'{CUR_CYC, MEAS_CYC, ETM_CYC, OFS_CYC};

	// ======================================================================
	// Helpers.
	// Block number of a shadow index; fixed block sizes 16, 16, 8.
	function automatic logic [1:0] bm_blk(input logic [5:0] i);
		if (i < `BM_NV_B1) begin
			return 2'h0;
		end else if (i < `BM_NV_B2) begin
			return 2'h1;
		end
		return 2'h2;
	endfunction : bm_blk

	// Value of the two-byte register whose upper byte lives at a.
	function automatic logic [15:0] bm_pair(input logic [7:0] a);
		unique case (a)
			`BM_A_ETM_H:  return etm_reg;
			`BM_A_VOLT_H: return volt_reg;
			`BM_A_CUR_H:  return cur_reg;
			`BM_A_ACC_H:  return acc_reg;
			`BM_A_TMP_H:  return temp_reg;
			default:      return 16'h0000;
		endcase
	endfunction : bm_pair

	// True when a is the upper byte of a two-byte register.
	function automatic logic bm_is_pair(input logic [7:0] a);
		return a == `BM_A_ETM_H || a == `BM_A_VOLT_H ||
			a == `BM_A_CUR_H || a == `BM_A_ACC_H ||
			a == `BM_A_TMP_H;
	endfunction : bm_is_pair

	// ======================================================================
	// Command decode.
	// Block index and pair values are decoded once here; single registers compare hc_addr where used.
	always_comb begin
		cmd    = hc_valid;
		wr     = hc_valid && hc_op == BM_OP_WRITE;
		rd     = hc_valid && hc_op == BM_OP_READ;
		nv_hit = hc_addr >= `BM_NV_BASE && hc_addr <= `BM_NV_LAST;
		nv_idx = 6'(hc_addr - `BM_NV_BASE);
		nv_blk = bm_blk(nv_idx);
		// A function result cannot be sliced, so the pairs land here.
		pair_up = bm_pair(hc_addr);
		pair_dn = bm_pair(hc_addr - 8'h01);
	end

	// ======================================================================
	// Rate dividers.
	// One counter per rate; each emits a single-cycle enable pulse.
	always_ff @(posedge ref_clk) begin
		for (int k = 0; k < 4; k++) begin
			if (!rst_b) begin
				div_cnt[k] <= 40'h0;
				tick[k]    <= 1'b0;
			end else if (div_cnt[k] >= 40'(DIV_LEN[k] - 1)) begin
				div_cnt[k] <= 40'h0;
				tick[k]    <= 1'b1;
			end else begin
				div_cnt[k] <= div_cnt[k] + 40'h1;
				tick[k]    <= 1'b0;
			end
		end
	end

	// ======================================================================
	// Current path.
	// Bias comes from the shadow bytes, so a host write takes effect at
	// once, before any copy to the cells.
	always_comb begin
		cur_diff = 18'(signed'(cur_raw)) - 18'(cur_ofs)
			- 18'(signed'({sh[`BM_NV_BIAS_H],
			sh[`BM_NV_BIAS_L]}));
		// A positive bias makes the difference more negative.
		if (cur_diff > 18'sh07fff) begin
			cur_corr = 16'sh7fff;
		end else if (cur_diff < -18'sh08000) begin
			cur_corr = -16'sh8000;
		end else begin
			cur_corr = 16'(cur_diff);
		end
	end

	// Offset estimate is refreshed on the hourly pulse; the converter
	// supplies a zero-input sample, so one refresh trims to one count.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			cur_ofs <= 16'sh0000;
		end else if (tick[3]) begin
			cur_ofs <= signed'(cur_zero);
		end
	end

	// The reported current is the converter's interval average, clamped.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			cur_reg <= 16'sh0000;
		end else if (tick[0]) begin
			cur_reg <= cur_corr;
		end
	end

	// ======================================================================
	// Charge accumulator.
	// One current count held for one interval is 1/4091 of a count here,
	// for either sense option, so a remainder carries the fraction. The
	// remainder is drained one count per clock, far faster than needed.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			acc_reg <= 16'sh0000;
			acc_res <= 20'sh00000;
		end else if (wr && hc_addr == `BM_A_ACC_H) begin
			acc_reg[15:8] <= hc_wdata;
		end else if (wr && hc_addr == `BM_A_ACC_L) begin
			acc_reg[7:0] <= hc_wdata;
		end else if (tick[0]) begin
			acc_res <= acc_res + 20'(cur_corr);
		end else if (acc_res >= `BM_ACC_DIV) begin
			acc_res <= acc_res - `BM_ACC_DIV;
			acc_reg <= acc_reg + 16'sh0001;
		end else if (acc_res <= -`BM_ACC_DIV) begin
			acc_res <= acc_res + `BM_ACC_DIV;
			acc_reg <= acc_reg - 16'sh0001;
		end
	end

	// ======================================================================
	// Voltage and temperature.
	// Voltage never wraps: anything past full scale reads as full scale.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			volt_reg <= 16'h0000;
			temp_reg <= 16'h0000;
		end else if (tick[1]) begin
			if (volt_raw > `BM_VOLT_MAX) begin
				volt_reg <= `BM_VOLT_MAX;
			end else begin
				volt_reg <= volt_raw;
			end
			temp_reg <= temp_raw;
		end
	end

	// ======================================================================
	// Elapsed timer.
	// A host write wins over a tick in the same cycle.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			etm_reg <= 16'h0000;
		end else if (wr && hc_addr == `BM_A_ETM_H) begin
			etm_reg[15:8] <= hc_wdata;
		end else if (wr && hc_addr == `BM_A_ETM_L) begin
			etm_reg[7:0] <= hc_wdata;
		end else if (tick[2]) begin
			etm_reg <= etm_reg + 16'h0001;
		end
	end

	// ======================================================================
	// Charge time limit.
	// Loaded from the cell, not the shadow, so unsaved edits are unused.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			charge_time_limit <= 8'h00;
		end else if (fast_charge_start) begin
			charge_time_limit <= nv[`BM_NV_CTR];
		end else if (wr && hc_addr == `BM_A_CTR) begin
			charge_time_limit <= hc_wdata;
		end else if (tick[2] && fast_charging &&
			charge_time_limit != 8'h00) begin
			charge_time_limit <= charge_time_limit - 8'h01;
		end
	end

	// ======================================================================
	// Status register.
	// Configuration bits come straight from the cell at power-up and on
	// refresh; host writes never touch them.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			cfg_pend        <= 1'b1;
			sleep_enable    <= 1'b0;
			net_opcode_sel  <= 1'b0;
			charge_init_sel <= 1'b0;
			charge_type     <= 1'b0;
		end else if (cfg_pend ||
			(cmd && hc_op == BM_OP_REFRESH)) begin
			cfg_pend        <= 1'b0;
			sleep_enable    <= nv[`BM_NV_STAT][`BM_ST_SLEEP];
			net_opcode_sel  <= nv[`BM_NV_STAT][`BM_ST_OPSEL];
			charge_init_sel <= nv[`BM_NV_STAT][`BM_ST_CINI];
			charge_type     <= nv[`BM_NV_STAT][`BM_ST_CTYPE];
		end
	end

	// Completion latch: a new completion beats a clearing write.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			done_lat <= 1'b0;
		end else if (charge_done) begin
			done_lat <= 1'b1;
		end else if (wr && hc_addr == `BM_A_STATUS) begin
			done_lat <= 1'b0;
		end
	end

	// Two-bit charge status; completion overrides the charger code.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			charge_state_hi <= 1'b0;
			charge_state_lo <= 1'b0;
		end else if ((done_lat && !(wr && hc_addr == `BM_A_STATUS)) ||
			charge_done) begin
			// A clearing write shows on the next cycle, like the latch.
			charge_state_hi <= 1'b1;
			charge_state_lo <= 1'b1;
		end else begin
			charge_state_hi <= charge_state_in[1];
			charge_state_lo <= charge_state_in[0];
		end
	end

	// ======================================================================
	// Nonvolatile control: locks, lock arming, copy busy.
	// Lock arming is dropped by any command other than read, write or end after it was set.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			blk_lock <= 3'h0;
			lock_en  <= 1'b0;
			busy_cnt <= 16'h0000;
			copy_busy <= 1'b0;
		end else begin
			if (wr && hc_addr == `BM_A_NVC) begin
				lock_en <= hc_wdata[`BM_NVC_LOCK];
			end else if (cmd && hc_op != BM_OP_READ &&
				hc_op != BM_OP_WRITE && hc_op != BM_OP_END) begin
				lock_en <= 1'b0;
			end
			if (cmd && hc_op == BM_OP_LOCK && lock_en && nv_hit) begin
				blk_lock[nv_blk] <= 1'b1;
			end
			if (cmd && hc_op == BM_OP_COPY && nv_hit &&
				!blk_lock[nv_blk]) begin
				busy_cnt  <= COPY_CYC;
				copy_busy <= 1'b1;
			end else if (busy_cnt != 16'h0000) begin
				busy_cnt  <= busy_cnt - 16'h0001;
				copy_busy <= busy_cnt != 16'h0001;
			end
		end
	end

	// Cells: cleared at reset, programmed only by copy of an unlocked
	// block. The whole block is written at the start of the busy time.
	always_ff @(posedge ref_clk) begin
		for (int i = 0; i < `BM_NV_BYTES; i++) begin
			if (!rst_b) begin
				nv[i] <= 8'h00;
			end else if (cmd && hc_op == BM_OP_COPY && nv_hit &&
				!blk_lock[nv_blk] && bm_blk(6'(i)) == nv_blk) begin
				nv[i] <= sh[i];
			end
		end
	end

	// Shadow: host writes land here unless locked or copying.
	always_ff @(posedge ref_clk) begin
		for (int i = 0; i < `BM_NV_BYTES; i++) begin
			if (!rst_b) begin
				sh[i] <= 8'h00;
			end else if (cmd && hc_op == BM_OP_RECALL && nv_hit &&
				bm_blk(6'(i)) == nv_blk) begin
				sh[i] <= nv[i];
			end else if (wr && nv_hit && nv_idx == 6'(i) &&
				!blk_lock[nv_blk] && !copy_busy) begin
				sh[i] <= hc_wdata;
			end
		end
	end

	// General-purpose scratch memory.
	always_ff @(posedge ref_clk) begin
		for (int i = 0; i < `BM_RAM_BYTES; i++) begin
			if (!rst_b) begin
				ram[i] <= 8'h00;
			end else if (wr && hc_addr == `BM_RAM_BASE + 8'(i)) begin
				ram[i] <= hc_wdata;
			end
		end
	end

	// ======================================================================
	// Read path.
	// Live value of any address; unmapped ones read zero.
	always_comb begin
		rd_byte = 8'h00;
		if (nv_hit) begin
			rd_byte = sh[nv_idx];
		end else if (hc_addr >= `BM_RAM_BASE &&
			hc_addr <= `BM_RAM_LAST) begin
			rd_byte = ram[hc_addr[3:0]];
		end else if (hc_addr == `BM_A_STATUS) begin
			rd_byte = {charge_state_hi, charge_state_lo,
				sleep_enable, net_opcode_sel, 2'b00,
				charge_init_sel, charge_type};
		end else if (hc_addr == `BM_A_CTR) begin
			rd_byte = charge_time_limit;
		end else if (hc_addr == `BM_A_NVC) begin
			rd_byte = {copy_busy, lock_en, 3'b000, blk_lock};
		end else if (bm_is_pair(hc_addr)) begin
			rd_byte = pair_up[15:8];
		end else if (bm_is_pair(hc_addr - 8'h01)) begin
			rd_byte = pair_dn[7:0];
		end
	end

	// Freeze: reading an upper byte holds the lower byte until an end
	// command comes, so the two halves always belong together.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			frz_on   <= 1'b0;
			frz_addr <= 8'h00;
			frz_lo   <= 8'h00;
		end else if (cmd && hc_op == BM_OP_END) begin
			frz_on <= 1'b0;
		end else if (rd && bm_is_pair(hc_addr)) begin
			frz_on   <= 1'b1;
			frz_addr <= hc_addr;
			frz_lo   <= pair_up[7:0];
		end
	end

	// Registered answer, one cycle after the read strobe.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			hc_rdata  <= 8'h00;
			hc_rvalid <= 1'b0;
		end else begin
			hc_rvalid <= rd;
			if (rd && frz_on && hc_addr == frz_addr + 8'h01) begin
				hc_rdata <= frz_lo;
			end else if (rd) begin
				hc_rdata <= rd_byte;
			end
		end
	end

endmodule : bm_register_map

/* bm_register_map_asserts.sv */
// ==========================================================================
// Port-level checks of the battery monitor register map.
module bm_register_map_asserts
	import bm_pkg::*;
#(
	parameter logic [15:0] COPY_CYC = 16'h0008
) (
	input wire logic       ref_clk,
	input wire logic       rst_b,
	input wire logic       hc_valid,
	input wire bm_op_t     hc_op,
	input wire logic [7:0] hc_addr,
	input wire logic [7:0] hc_wdata,
	input wire logic       charge_done,
	input wire logic [1:0] charge_state_in,
	input wire logic       fast_charge_start,
	input wire logic       fast_charging,
	input wire logic [7:0] hc_rdata,
	input wire logic       hc_rvalid,
	input wire logic       charge_state_hi,
	input wire logic       charge_state_lo,
	input wire logic       sleep_enable,
	input wire logic       net_opcode_sel,
	input wire logic       charge_init_sel,
	input wire logic       charge_type,
	input wire logic [7:0] charge_time_limit,
	input wire logic       copy_busy
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	logic        is_rd;    // A read command is taken at this edge.
	logic        wr_st;    // A write to the status address is taken.
	logic        done_st;  // Completion code is shown.
	logic [15:0] busy_cnt; // Length of the running copy.
	assign is_rd = hc_valid && (hc_op == BM_OP_READ);
	assign wr_st = hc_valid && (hc_op == BM_OP_WRITE) && (hc_addr == 8'h01);
	assign done_st = charge_state_hi && charge_state_lo;
	// Count busy cycles so a copy of the wrong length is seen at its end.
	always_ff @(posedge ref_clk) begin
		if (!rst_b || !copy_busy) begin
			busy_cnt <= 16'h0000;
		end else begin
			busy_cnt <= busy_cnt + 16'h0001;
		end
	end
	a_read_answer: assert property (
		is_rd |=> hc_rvalid) else $error("read got no answer");
	a_answer_cause: assert property (
		hc_rvalid |-> $past(is_rd)) else $error("answer without read");
	a_rdata_hold: assert property (
		!hc_rvalid |-> $stable(hc_rdata)) else $error("read data moved");
	a_done_set: assert property (
		charge_done |=> done_st) else $error("completion not shown");
	a_done_hold: assert property (
		done_st && !wr_st |=> done_st) else $error("completion lost");
	a_done_clear: assert property (
		wr_st && !charge_done && charge_state_in != 2'b11 |=> !done_st)
		else $error("status write left completion");
	a_copy_start: assert property (
		$rose(copy_busy) |-> $past(hc_valid && hc_op == BM_OP_COPY))
		else $error("busy without copy");
	a_copy_len: assert property (
		$fell(copy_busy) |-> busy_cnt == COPY_CYC)
		else $error("copy length wrong");
	a_cfg_refresh: assert property (
		$changed({sleep_enable, net_opcode_sel, charge_init_sel, charge_type})
		|-> $past(hc_valid && hc_op == BM_OP_REFRESH))
		else $error("status config moved without refresh");
	a_ctime_write: assert property (
		hc_valid && hc_op == BM_OP_WRITE && hc_addr == 8'h06
		&& !fast_charge_start && !fast_charging
		|=> charge_time_limit == $past(hc_wdata))
		else $error("charge time write lost");
endmodule : bm_register_map_asserts

/* bm_host_model.sv */
// ==========================================================================
// Host side of the command port: one command per call, one idle cycle after.
module bm_host_model
	import bm_pkg::*;
(
	input  wire logic      ref_clk,
	output logic           hc_valid,
	output bm_op_t         hc_op,
	output logic [7:0]     hc_addr,
	output logic [7:0]     hc_wdata,
	input  wire logic [7:0] hc_rdata,
	input  wire logic      hc_rvalid
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		hc_valid = 1'b0;
		hc_op = BM_OP_END;
		hc_addr = 8'h00;
		hc_wdata = 8'h00;
	end
	// Holds the request until the taking edge; released lines carry junk.
	task automatic cmd(input bm_op_t op, input bm_byte_t a, input bm_byte_t d);
		@(posedge ref_clk);
		#1;
		hc_valid = 1'b1;
		hc_op = op;
		hc_addr = a;
		hc_wdata = d;
		@(posedge ref_clk);
		#1;
		hc_valid = 1'b0;
		hc_addr = ~a;
		hc_wdata = ~d;
	endtask : cmd
	// The answer is sampled just after the taking edge; none gives unknown.
	task automatic rd(input bm_byte_t a, output bm_byte_t v);
		cmd(BM_OP_READ, a, 8'h00);
		v = hc_rvalid ? hc_rdata : 8'hxx;
	endtask : rd
	// Both bytes of a pair in two reads before one end command, upper byte first.
	task automatic rd16(input bm_byte_t a, output logic [15:0] v);
		rd(a, v[15:8]);
		rd(a + 8'h01, v[7:0]);
		cmd(BM_OP_END, 8'h00, 8'h00);
	endtask : rd16
endmodule : bm_host_model

/* battery_monitor_register_map_tb.sv */
// ==========================================================================
// Register map bench: command sequences against expected values.
module battery_monitor_register_map_tb
	import bm_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic hc_valid, hc_rvalid, charge_done, fast_charge_start, fast_charging;
	logic charge_state_hi, charge_state_lo, sleep_enable, copy_busy;
	logic net_opcode_sel, charge_init_sel, charge_type;
	bm_op_t hc_op;
	logic [7:0] hc_addr, hc_wdata, hc_rdata, charge_time_limit, v;
	logic [15:0] cur_raw, cur_zero, volt_raw, temp_raw, w;
	logic [1:0] charge_state_in;
	int err_count = 0;
	int n_compared = 0;
	always #2 ref_clk = ~ref_clk;
	// Short tick spacings keep the run within a few thousand cycles.
	bm_register_map #(.CUR_CYC(40), .MEAS_CYC(10), .ETM_CYC(20),
		.OFS_CYC(200), .COPY_CYC(16'h0008)) dut_u (.ref_clk(ref_clk),
		.rst_b(rst_b), .hc_valid(hc_valid), .hc_op(hc_op),
		.hc_addr(hc_addr), .hc_wdata(hc_wdata), .cur_raw(cur_raw),
		.cur_zero(cur_zero), .volt_raw(volt_raw), .temp_raw(temp_raw),
		.charge_state_in(charge_state_in), .charge_done(charge_done),
		.fast_charge_start(fast_charge_start),
		.fast_charging(fast_charging), .hc_rdata(hc_rdata),
		.hc_rvalid(hc_rvalid), .charge_state_hi(charge_state_hi),
		.charge_state_lo(charge_state_lo), .sleep_enable(sleep_enable),
		.net_opcode_sel(net_opcode_sel), .charge_init_sel(charge_init_sel),
		.charge_type(charge_type),
		.charge_time_limit(charge_time_limit), .copy_busy(copy_busy));
	bm_host_model host_u (.ref_clk(ref_clk), .hc_valid(hc_valid),
		.hc_op(hc_op), .hc_addr(hc_addr), .hc_wdata(hc_wdata),
		.hc_rdata(hc_rdata), .hc_rvalid(hc_rvalid));
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc
	task automatic chk(input string nm, input bm_byte_t e, input bm_byte_t g);
		n_compared++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask : chk
	task automatic wr(input bm_byte_t a, input bm_byte_t d);
		host_u.cmd(BM_OP_WRITE, a, d);
	endtask : wr
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : final_report
	// Watchdog: the sequence needs just under a thousand cycles.
	initial begin
		repeat (20000) @(posedge ref_clk);
		err_count++;
		final_report();
	end
	initial begin
		{charge_done, fast_charge_start, fast_charging} = 3'h0;
		{cur_raw, cur_zero, volt_raw, temp_raw} = {16'h4000, 16'h0000,
			16'h0123, 16'hfff0};
		charge_state_in = 2'b01;
		cyc(20);
		rst_b = 1'b1;
		cyc(1);
		host_u.rd(8'h01, v);
		chk("status", 8'h40, v);
		wr(8'h00, 8'hff);
		host_u.rd(8'h00, v);
		chk("rsvd", 8'h00, v);
		wr(8'h32, 8'h00);
		wr(8'h33, 8'h10);
		cyc(90);
		host_u.rd(8'h0c, v);
		chk("volt_h", 8'h01, v);
		volt_raw = 16'h7fff;
		cyc(25);
		host_u.rd(8'h0d, v);
		chk("volt_frz", 8'h23, v);
		host_u.cmd(BM_OP_END, 8'h00, 8'h00);
		host_u.rd16(8'h0c, w);
		chk("vclamp", 8'h03, w[15:8]);
		chk("vclamp_l", 8'hff, w[7:0]);
		host_u.rd16(8'h18, w);
		chk("temp_l", 8'hf0, w[7:0]);
		host_u.rd16(8'h0e, w);
		chk("cur_l", 8'hf0, w[7:0]);
		chk("cur_h", 8'h3f, w[15:8]);
		wr(8'h10, 8'h00);
		wr(8'h11, 8'h00);
		cyc(130);
		// Four intervals of 3ff0h: four whole counts each, small remainder.
		host_u.rd16(8'h10, w);
		chk("acc_up_h", 8'h00, w[15:8]);
		chk("acc_up_l", 8'h10, w[7:0]);
		cur_raw = 16'hc000;
		cyc(260);
		// Six discharge intervals take four counts each, ending below zero.
		host_u.rd16(8'h10, w);
		chk("acc_dn_h", 8'hff, w[15:8]);
		chk("acc_dn_l", 8'hf8, w[7:0]);
		wr(8'h02, 8'hff);
		wr(8'h03, 8'hff);
		cyc(21);
		host_u.rd16(8'h02, w);
		chk("etm_wrap", 8'h00, w[15:8]);
		chk("etm_lo", 8'h01, w[7:0]);
		charge_done = 1'b1;
		cyc(1);
		charge_done = 1'b0;
		cyc(4);
		host_u.rd(8'h01, v);
		chk("done", 8'hc0, v);
		wr(8'h01, 8'h00);
		host_u.rd(8'h01, v);
		chk("clr", 8'h40, v);
		wr(8'h20, 8'h55);
		host_u.rd(8'h20, v);
		chk("shadow", 8'h55, v);
		wr(8'h07, 8'h40);
		host_u.cmd(BM_OP_LOCK, 8'h2a, 8'h00);
		host_u.rd(8'h07, v);
		chk("locks", 8'h01, v);
		wr(8'h20, 8'haa);
		host_u.rd(8'h20, v);
		chk("locked", 8'h55, v);
		host_u.cmd(BM_OP_COPY, 8'h20, 8'h00);
		chk("no_busy", 8'h00, {7'h0, copy_busy});
		wr(8'h31, 8'h33);
		wr(8'h34, 8'h5a);
		host_u.cmd(BM_OP_REFRESH, 8'h00, 8'h00);
		host_u.rd(8'h01, v);
		chk("no_copy", 8'h40, v);
		host_u.cmd(BM_OP_COPY, 8'h30, 8'h00);
		chk("busy", 8'h01, {7'h0, copy_busy});
		cyc(10);
		host_u.cmd(BM_OP_REFRESH, 8'h00, 8'h00);
		host_u.rd(8'h01, v);
		chk("refresh", 8'h73, v);
		chk("sleep", 8'h01, {7'h0, sleep_enable});
		v = {5'h00, net_opcode_sel, charge_init_sel, charge_type};
		chk("cfg_pins", 8'h07, v);
		fast_charge_start = 1'b1;
		cyc(1);
		fast_charge_start = 1'b0;
		cyc(1);
		host_u.rd(8'h06, v);
		chk("ctime", 8'h5a, v);
		wr(8'h06, 8'h07);
		host_u.rd(8'h06, v);
		chk("ctw", 8'h07, v);
		chk("ctw_pin", 8'h07, charge_time_limit);
		wr(8'h31, 8'h00);
		host_u.cmd(BM_OP_RECALL, 8'h3f, 8'h00);
		host_u.rd(8'h31, v);
		chk("recall", 8'h33, v);
		wr(8'h47, 8'h3c);
		host_u.rd(8'h47, v);
		chk("blk2", 8'h3c, v);
		wr(8'h48, 8'h3c);
		host_u.rd(8'h48, v);
		chk("gap", 8'h00, v);
		wr(8'h8f, 8'hc3);
		host_u.rd(8'h8f, v);
		chk("sram", 8'hc3, v);
		// The zero sample is taken on the slow offset pulse and shows at
		// the next current update, well inside the wait.
		cur_zero = 16'h0020;
		cyc(250);
		host_u.rd16(8'h0e, w);
		chk("ofs_h", 8'hbf, w[15:8]);
		chk("ofs_l", 8'hd0, w[7:0]);
		final_report();
	end
endmodule : battery_monitor_register_map_tb
bind bm_register_map bm_register_map_asserts #(.COPY_CYC(COPY_CYC)) chk_u (
	.ref_clk(ref_clk), .rst_b(rst_b), .hc_valid(hc_valid), .hc_op(hc_op),
	.hc_addr(hc_addr), .hc_wdata(hc_wdata), .charge_done(charge_done),
	.charge_state_in(charge_state_in), .fast_charge_start(fast_charge_start),
	.fast_charging(fast_charging), .hc_rdata(hc_rdata),
	.hc_rvalid(hc_rvalid), .charge_state_hi(charge_state_hi),
	.charge_state_lo(charge_state_lo), .sleep_enable(sleep_enable),
	.net_opcode_sel(net_opcode_sel), .charge_init_sel(charge_init_sel),
	.charge_type(charge_type), .charge_time_limit(charge_time_limit),
	.copy_busy(copy_busy));
